// >>> rtc_guard_consts.vh
`ifndef RTC_GUARD_CONSTS_VH
`define RTC_GUARD_CONSTS_VH

// Register byte offsets owned by this block
`define OFS_TAMPER_CONFIG   8'h40
`define OFS_ALARM0_SUBSEC   8'h44
`define OFS_ALARM1_SUBSEC   8'h48
`define OFS_PRIV_GUARD      8'h50

// Offsets of the neighbouring clock registers that are only gated here
`define OFS_TIME            8'h00
`define OFS_DATE            8'h04
`define OFS_CTRL            8'h08
`define OFS_PRESCALER       8'h10
`define OFS_WAKEUP          8'h14
`define OFS_CLOCK_OUT       8'h18
`define OFS_ALARM0_TD       8'h1C
`define OFS_ALARM1_TD       8'h20
`define OFS_SHIFT_CTRL      8'h2C
`define OFS_STAMP_TIME      8'h30
`define OFS_STAMP_SUBSEC    8'h38
`define OFS_BACKUP_BASE     9'h100
`define BACKUP_WORDS        32
`define ZONE_A_WORDS        8
`define ZONE_B_WORDS        8

// Tamper configuration fields
`define TC_WIPE             31
`define TC_KEEP1            20
`define TC_KEEP0            19
`define TC_ALARM_PUSHPULL   18
`define TC_PULLUP_OFF       15
`define TC_PRECHARGE_LENGTH_HI          14
`define TC_PRECHARGE_LENGTH_LO          13
`define TC_FLT_HI           12
`define TC_FLT_LO           11
`define TC_RATE_HI          10
`define TC_RATE_LO          8
`define TC_TO_STAMP         7
`define TC_POL1             4
`define TC_ON1              3
`define TC_IRQ_ON           2
`define TC_POL0             1
`define TC_ON0              0
`define TC_WR_MASK          32'h001C_FF9F

// Alarm sub-second fields
`define SS_WIDTH_HI         27
`define SS_WIDTH_LO         24
`define SS_WR_MASK          32'h0F00_7FFF

// Privilege guard fields
`define PG_ZONE_B           31
`define PG_ZONE_A           30
`define PG_GLOBAL           15
`define PG_CALENDAR         14
`define PG_CALIB            13
`define PG_TAMPER           12
`define PG_STAMP            3
`define PG_WAKEUP           2
`define PG_ALARM1           1
`define PG_ALARM0           0
`define PG_WR_MASK          32'hC000_F00F

`define REG_RESET           32'h0000_0000

// Sampling: base period is 2**15 clocks at rate code 0
`define SAMPLE_BASE_LOG2    15

`endif

// >>> tamper_channel.v
`timescale 1ns/1ps
`include "rtc_guard_consts.vh"

// One tamper input: pin synchroniser, edge detector and level filter
module tamper_channel (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       pin_i,
  input  wire       on_i,
  input  wire       polarity_i,
  input  wire [1:0] filter_i,
  input  wire       sample_i,
  output reg        event_o
);

  reg [2:0] sync;
  reg       level;
  reg       level_prev;
  reg [3:0] hits;

  wire [3:0] target = 4'h1 << filter_i;
  // Level mode: polarity 1 means high is active, 0 means low
  wire       active = ~(level ^ polarity_i);               // [RULE_09]
  // Edge mode: polarity 0 rising, 1 falling
  wire       edge_seen = polarity_i ? (level_prev & ~level)
                                    : (~level_prev & level); // [RULE_09]

  always @(posedge clk_i) begin
    if (rst_i) begin
      sync       <= 3'h0;
      level      <= 1'b0;
      level_prev <= 1'b0;
    end else begin
      sync <= {sync[1:0], pin_i};
      if (sync[1] == sync[2])
        level <= sync[2];
      level_prev <= level;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      hits    <= 4'h0;
      event_o <= 1'b0;
    end else begin
      event_o <= 1'b0;
      if (!on_i) begin                                     // [RULE_10]
        hits <= 4'h0;
      end else if (filter_i == 2'h0) begin                 // [RULE_05]
        hits    <= 4'h0;
        event_o <= edge_seen;
      end else if (sample_i) begin
        // Count saturates at the target so a held level fires only once
        if (!active)
          hits <= 4'h0;
        else if (hits + 4'h1 == target) begin              // [RULE_06]
          hits    <= target;
          event_o <= 1'b1;
        end else if (hits != target)
          hits <= hits + 4'h1;
      end
    end
  end

endmodule

// >>> rtc_tamper_subsec_alarm_priv.v
`timescale 1ns/1ps
`include "rtc_guard_consts.vh"

// Overview of operation
// RULE_01: Writing one to the wipe trigger erases backup; it always reads zero.
// RULE_02: A tamper event wipes backup unless that input's keep bit is set.
// RULE_03: With pull-up not disabled, pins are pre-charged before each sample.
// RULE_04: Pre-charge length code 0..3 gives 1, 2, 4 or 8 clocks.
// RULE_05: Filter code zero selects edge detection and turns pre-charge off.
// RULE_06: Filter codes 1..3 need 2, 4 or 8 consecutive active samples.
// RULE_07: Sample rate code 0 samples every 32768 clocks, halving per step.
// RULE_08: Tamper-to-stamp makes a tamper event also set the stamp flag.
// RULE_09: Polarity picks rising/falling edge or low/high level per input.
// RULE_10: Each input detects only while its own enable bit is one.
// RULE_11: Tamper interrupt request is raised only while its enable is one.
// RULE_12: Software should disable tamper inputs before reconfiguring them.
// RULE_13: Alarm sub-second writes need that alarm off or calendar init mode.
// RULE_14: Match width zero skips the sub-second compare entirely.
// RULE_15: Match width n compares only the low n counter bits.
// RULE_16: Stored sub-second is 15 bits; counter bit 15 is never compared.
// RULE_17: Zone B guard makes zone B backup writes privileged only.
// RULE_18: Zone A guard makes zone A backup reads and writes privileged only.
// RULE_19: Global guard makes all other clock register writes privileged only.
// RULE_20: Calendar guard protects time, date and prescaler writes.
// RULE_21: Calibration guard protects shift, clock-output and control writes.
// RULE_22: Tamper, stamp, wakeup and alarm 1 guards protect their own writes.
// RULE_23: Alarm 0 guard protects alarm 0 configuration writes.
// RULE_24: A tamper event on input 0 or 1 sets that input's seen flag.
// RULE_25: Alarms compare against the live synchronous prescaler count.
// RULE_26: Refused writes are dropped and leave the register unchanged.
// RULE_27: Privilege of each access comes from the APB protection sideband.
module rtc_tamper_subsec_alarm_priv #(
  parameter SAMPLE_BASE_LOG2 = `SAMPLE_BASE_LOG2
) (
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [2:0]  pprot_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  output reg         ext_wr_o,
  output reg         ext_rd_o,
  output reg  [11:0] ext_addr_o,
  output reg  [31:0] ext_wdata_o,
  input  wire [31:0] ext_rdata_i,
  input  wire [1:0]  tamper_pin_i,
  output reg         tamper_pullup_o,
  input  wire        alarm0_on_i,
  input  wire        alarm1_on_i,
  input  wire        calendar_init_mode_i,
  input  wire [15:0] subsec_count_i,
  output reg         alarm0_subsec_match_o,
  output reg         alarm1_subsec_match_o,
  output reg         backup_wipe_o,
  output reg         stamp_flag_set_o,
  output reg  [1:0]  tamper_seen_o,
  input  wire [1:0]  tamper_seen_clr_i,
  output reg         tamper_irq_o,
  output reg         alarm_pushpull_o
);

  localparam [3:0] C_NONE     = 4'd0;
  localparam [3:0] C_TAMPER   = 4'd1;
  localparam [3:0] C_ALARM0   = 4'd2;
  localparam [3:0] C_ALARM1   = 4'd3;
  localparam [3:0] C_PRIV     = 4'd4;

  localparam [3:0] C_CALENDAR = 4'd5;
  localparam [3:0] C_CALIB    = 4'd6;
  localparam [3:0] C_STAMP    = 4'd7;
  localparam [3:0] C_WAKEUP   = 4'd8;
  localparam [3:0] C_ZONE_A   = 4'd9;
  localparam [3:0] C_ZONE_B   = 4'd10;
  localparam [3:0] C_ZONE_C   = 4'd11;
  localparam [3:0] C_A0_TD    = 4'd12;
  localparam [3:0] C_A1_TD    = 4'd13;

  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_WAIT = 3'b010;
  localparam [2:0] S_DONE = 3'b100;

  // Sized from the base so tests can shrink the period
  localparam [SAMPLE_BASE_LOG2-1:0] CNT_ONE = {{(SAMPLE_BASE_LOG2-1){1'b0}}, 1'b1};

  reg [31:0] tamper_config;
  reg [31:0] alarm0_subsecond;
  reg [31:0] alarm1_subsecond;
  reg [31:0] privilege_guard_control;

  reg [2:0]  state;
  reg        refused;
  reg [SAMPLE_BASE_LOG2-1:0] sample_cnt;
  reg        sample_strobe;

  wire [1:0] tamper_event;

  // Address class of a word offset
  function [3:0] addr_class;
    input [11:0] a;
    reg   [11:0] word;
    begin
      word = (a - {3'h0, `OFS_BACKUP_BASE}) >> 2;
      addr_class = C_NONE;
      if (a[1:0] != 2'b00)
        addr_class = C_NONE;
      else if (a >= {3'h0, `OFS_BACKUP_BASE} && word < `BACKUP_WORDS) begin
        if (word < `ZONE_A_WORDS)
          addr_class = C_ZONE_A;
        else if (word < `ZONE_A_WORDS + `ZONE_B_WORDS)
          addr_class = C_ZONE_B;
        else
          addr_class = C_ZONE_C;
      end else if (a[11:8] == 4'h0) begin
        case (a[7:0])
          `OFS_TAMPER_CONFIG: addr_class = C_TAMPER;
          `OFS_ALARM0_SUBSEC: addr_class = C_ALARM0;
          `OFS_ALARM1_SUBSEC: addr_class = C_ALARM1;
          `OFS_PRIV_GUARD:    addr_class = C_PRIV;
          `OFS_TIME, `OFS_DATE, `OFS_PRESCALER:
            addr_class = C_CALENDAR;
          `OFS_CTRL, `OFS_CLOCK_OUT, `OFS_SHIFT_CTRL:
            addr_class = C_CALIB;
          `OFS_WAKEUP:        addr_class = C_WAKEUP;
          `OFS_ALARM0_TD:     addr_class = C_A0_TD;
          `OFS_ALARM1_TD:     addr_class = C_A1_TD;
          8'h30, 8'h34, `OFS_STAMP_SUBSEC:
            addr_class = C_STAMP;
          default:            addr_class = C_NONE;
        endcase
      end
    end
  endfunction

  // Whether an access of this class passes the privilege guards
  function access_ok;
    input [3:0]  cls;
    input        wr;
    input        priv;
    input [31:0] g;
    reg          need;
    begin
      need = 1'b0;
      case (cls)
        C_ZONE_A:   need = g[`PG_ZONE_A];                       // [RULE_18]
        C_ZONE_B:   need = wr & g[`PG_ZONE_B];                  // [RULE_17]
        C_ZONE_C:   need = 1'b0;
        C_CALENDAR: need = wr & (g[`PG_CALENDAR] | g[`PG_GLOBAL]); // [RULE_20]
        C_CALIB:    need = wr & (g[`PG_CALIB] | g[`PG_GLOBAL]);    // [RULE_21]
        C_TAMPER:   need = wr & (g[`PG_TAMPER] | g[`PG_GLOBAL]);   // [RULE_22]
        C_STAMP:    need = wr & (g[`PG_STAMP] | g[`PG_GLOBAL]);    // [RULE_22]
        C_WAKEUP:   need = wr & (g[`PG_WAKEUP] | g[`PG_GLOBAL]);   // [RULE_22]
        C_ALARM1, C_A1_TD:
                    need = wr & (g[`PG_ALARM1] | g[`PG_GLOBAL]);   // [RULE_22]
        C_ALARM0, C_A0_TD:
                    need = wr & (g[`PG_ALARM0] | g[`PG_GLOBAL]);   // [RULE_23]
        C_PRIV:     need = wr & g[`PG_GLOBAL];                  // [RULE_19]
        default:    need = 1'b0;
      endcase
      access_ok = (cls != C_NONE) & (~need | priv);
    end
  endfunction

  // Sub-second compare over the low n bits; bit 15 of the count never enters
  function subsec_hit;
    input [31:0] r;
    input [15:0] cnt;
    reg   [14:0] mask;
    begin
      mask = ~(15'h7FFF << r[`SS_WIDTH_HI:`SS_WIDTH_LO]);          // [RULE_15]
      subsec_hit = (((cnt[14:0] ^ r[14:0]) & mask) == 15'h0000);   // [RULE_16]
    end
  endfunction

  wire [3:0] req_class = addr_class(paddr_i);
  wire       req_priv  = pprot_i[0];                                // [RULE_27]
  wire       req_ok    = access_ok(req_class, pwrite_i, req_priv,
                                   privilege_guard_control);

  wire       req_ext   = (req_class != C_TAMPER) && (req_class != C_ALARM0) &&
                         (req_class != C_ALARM1) && (req_class != C_PRIV);

  wire       a0_open   = ~alarm0_on_i | calendar_init_mode_i;       // [RULE_13]
  wire       a1_open   = ~alarm1_on_i | calendar_init_mode_i;       // [RULE_13]

  // Local writes land on the taking edge
  wire       wr_take   = (state == S_IDLE) & psel_i & penable_i & pwrite_i & req_ok;
  wire       wipe_wr   = wr_take & (req_class == C_TAMPER) & pwdata_i[`TC_WIPE];

  wire [1:0]  tamper_filter_count  = tamper_config[`TC_FLT_HI:`TC_FLT_LO];
  wire [1:0]  precharge_length = tamper_config[`TC_PRECHARGE_LENGTH_HI:`TC_PRECHARGE_LENGTH_LO];
  wire [2:0]  rate = tamper_config[`TC_RATE_HI:`TC_RATE_LO];
  // Small bases make high rate codes sample every clock
  wire [SAMPLE_BASE_LOG2-1:0] period_last =
    ({SAMPLE_BASE_LOG2{1'b1}} >> rate);                             // [RULE_07]
  wire [SAMPLE_BASE_LOG2-1:0] precharge_length_len = CNT_ONE << precharge_length;           // [RULE_04]
  wire        precharge_length_use = ~tamper_config[`TC_PULLUP_OFF] & (tamper_filter_count != 2'h0); // [RULE_05]

  // APB slave: two wait states, answer registered
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      state     <= S_IDLE;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= `REG_RESET;
      ext_wr_o  <= 1'b0;
      ext_rd_o  <= 1'b0;
      ext_addr_o  <= 12'h000;
      ext_wdata_o <= `REG_RESET;
      refused     <= 1'b0;
    end else begin
      ext_wr_o <= 1'b0;
      ext_rd_o <= 1'b0;
      pready_o <= 1'b0;
      case (state)
        S_IDLE: begin
          if (psel_i && penable_i) begin
            state       <= S_WAIT;
            ext_addr_o  <= paddr_i;
            ext_wdata_o <= pwdata_i;
            // Refused accesses report an error and never reach the target;
            // held back so the error rises with ready
            refused     <= ~req_ok;                                 // [RULE_26]
            ext_wr_o    <= pwrite_i & req_ok & req_ext;
            ext_rd_o    <= ~pwrite_i & req_ok & req_ext;
            prdata_o    <= `REG_RESET;
            if (!pwrite_i && req_ok) begin
              case (req_class)
                C_TAMPER: prdata_o <= tamper_config;                // [RULE_01]
                C_ALARM0: prdata_o <= alarm0_subsecond;
                C_ALARM1: prdata_o <= alarm1_subsecond;
                C_PRIV:   prdata_o <= privilege_guard_control;
                default:  prdata_o <= `REG_RESET;
              endcase
            end
          end
        end
        S_WAIT: begin
          // External read data returns one cycle after the strobe
          if (ext_rd_o)
            prdata_o <= ext_rdata_i;
          pready_o <= 1'b1;
          pslverr_o <= refused;
          state    <= S_DONE;
        end
        S_DONE: begin
          pslverr_o <= 1'b0;
          state     <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Local register writes
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      tamper_config           <= `REG_RESET;
      alarm0_subsecond        <= `REG_RESET;
      alarm1_subsecond        <= `REG_RESET;
      privilege_guard_control <= `REG_RESET;
    end else if (wr_take) begin
      case (req_class)
        C_TAMPER: tamper_config <= pwdata_i & `TC_WR_MASK;          // [RULE_01]
        C_ALARM0: if (a0_open)
                    alarm0_subsecond <= pwdata_i & `SS_WR_MASK;     // [RULE_26]
        C_ALARM1: if (a1_open)
                    alarm1_subsecond <= pwdata_i & `SS_WR_MASK;     // [RULE_26]
        C_PRIV:   privilege_guard_control <= pwdata_i & `PG_WR_MASK;
        default:  tamper_config <= tamper_config;
      endcase
    end
  end

  // Sample timer with pre-charge window just before each sample point
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      sample_cnt      <= {SAMPLE_BASE_LOG2{1'b0}};
      sample_strobe   <= 1'b0;
      tamper_pullup_o <= 1'b0;
    end else begin
      if (sample_cnt >= period_last) begin
        sample_cnt    <= {SAMPLE_BASE_LOG2{1'b0}};
        sample_strobe <= 1'b1;
      end else begin
        sample_cnt    <= sample_cnt + CNT_ONE;
        sample_strobe <= 1'b0;
      end
      // Pull-up covers the last precharge_length_len counts before the strobe
      tamper_pullup_o <= precharge_length_use &
                         (sample_cnt >= period_last - precharge_length_len) &
                         (sample_cnt < period_last);                // [RULE_03]
    end
  end

  // Both channels share the filter and the sample strobe
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : chan
      tamper_channel u_chan (
        .clk_i      (ref_clk_i),
        .rst_i      (rst_i),
        .pin_i      (tamper_pin_i[gi]),
        .on_i       (tamper_config[gi ? `TC_ON1 : `TC_ON0]),        // [RULE_10]
        .polarity_i (tamper_config[gi ? `TC_POL1 : `TC_POL0]),
        .filter_i   (tamper_filter_count),
        .sample_i   (sample_strobe),
        .event_o    (tamper_event[gi])
      );
    end
  endgenerate

  // Keep bits spare only the tamper wipe, not the trigger
  wire [1:0] tamper_erase = tamper_event &
    ~{tamper_config[`TC_KEEP1], tamper_config[`TC_KEEP0]};          // [RULE_02]

  // Event outputs; a set in the same cycle as a clear wins
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      backup_wipe_o         <= 1'b0;
      stamp_flag_set_o      <= 1'b0;
      tamper_seen_o         <= 2'b00;
      tamper_irq_o          <= 1'b0;
      alarm0_subsec_match_o <= 1'b0;
      alarm1_subsec_match_o <= 1'b0;
      alarm_pushpull_o      <= 1'b0;
    end else begin
      backup_wipe_o    <= wipe_wr | (|tamper_erase);                // [RULE_01] [RULE_02]
      stamp_flag_set_o <= tamper_config[`TC_TO_STAMP] & (|tamper_event); // [RULE_08]
      tamper_seen_o    <= (tamper_seen_o & ~tamper_seen_clr_i) | tamper_event; // [RULE_24]
      tamper_irq_o     <= tamper_config[`TC_IRQ_ON] & (|tamper_seen_o); // [RULE_11]

      alarm0_subsec_match_o <= subsec_hit(alarm0_subsecond, subsec_count_i); // [RULE_14] [RULE_25]
      alarm1_subsec_match_o <= subsec_hit(alarm1_subsecond, subsec_count_i); // [RULE_14] [RULE_25]
      alarm_pushpull_o <= tamper_config[`TC_ALARM_PUSHPULL];
    end
  end

endmodule

// >>> rtc_guard_asserts.sv
`timescale 1ns/1ps
module rtc_guard_asserts #(
  parameter SAMPLE_BASE_LOG2 = 15
) (
  input wire        ref_clk_i,
  input wire        rst_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire        ext_wr_o,
  input wire        ext_rd_o,
  input wire [11:0] ext_addr_o,
  input wire [31:0] ext_wdata_o,
  input wire        backup_wipe_o,
  input wire        stamp_flag_set_o,
  input wire [1:0]  tamper_seen_o,
  input wire [1:0]  tamper_seen_clr_i,
  input wire        tamper_irq_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  a_answer_latency: assert property ($rose(penable_i) && psel_i |-> ##2 pready_o)
    else $error("access not answered two cycles after it was taken");
  a_ready_single: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside an access phase");
  a_refuse_quiet: assert property (pslverr_o |-> pready_o && !$past(ext_wr_o || ext_rd_o))
    else $error("refused access reached an external register");
  a_ext_then_ok: assert property ((ext_wr_o || ext_rd_o) |=> pready_o && !pslverr_o)
    else $error("external strobe not followed by a clean answer");
  a_ext_wr_cause: assert property (ext_wr_o |-> psel_i && penable_i && pwrite_i &&
    ext_addr_o == paddr_i && ext_wdata_o == pwdata_i)
    else $error("external write strobe without a matching bus write");
  a_ext_rd_cause: assert property (ext_rd_o |-> psel_i && penable_i && !pwrite_i &&
    ext_addr_o == paddr_i)
    else $error("external read strobe without a matching bus read");
  a_wipe_pulse: assert property (backup_wipe_o |=> !backup_wipe_o)
    else $error("backup wipe longer than one cycle");
  a_stamp_pulse: assert property (stamp_flag_set_o |=> !stamp_flag_set_o)
    else $error("stamp flag set longer than one cycle");
  a_irq_source: assert property (tamper_irq_o |-> $past(|tamper_seen_o))
    else $error("tamper interrupt without a seen flag");
  a_seen_sticky: assert property (tamper_seen_o[0] && !tamper_seen_clr_i[0]
    |=> tamper_seen_o[0])
    else $error("tamper seen flag dropped without a clear");

  c_refused: cover property (pslverr_o);
  c_wipe: cover property (backup_wipe_o);
  c_irq: cover property (tamper_irq_o);
  c_ext_read: cover property (ext_rd_o);
endmodule

bind rtc_tamper_subsec_alarm_priv rtc_guard_asserts #(
  .SAMPLE_BASE_LOG2(SAMPLE_BASE_LOG2)
) u_guard_chk (
  .ref_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .pready_o, .pslverr_o, .ext_wr_o, .ext_rd_o, .ext_addr_o, .ext_wdata_o,
  .backup_wipe_o, .stamp_flag_set_o, .tamper_seen_o, .tamper_seen_clr_i,
  .tamper_irq_o
);

// >>> apb_master_model.sv
`timescale 1ns/1ps
module apb_master_model (
  input  wire        clk_i,
  input  wire        pready_i,
  input  wire        pslverr_i,
  input  wire [31:0] prdata_i,
  output reg         psel_o,
  output reg         penable_o,
  output reg         pwrite_o,
  output reg  [11:0] paddr_o,
  output reg  [31:0] pwdata_o,
  output reg  [2:0]  pprot_o
);
  initial begin
    psel_o = 1'h0;
    penable_o = 1'h0;
    pwrite_o = 1'h0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0;
    pprot_o = 3'h0;
  end

  // Request held until ready is sampled or 20 cycles pass; afterwards address and data are
  // inverted so the slave cannot lean on stale values
  task xfer(input w, input [11:0] a, input [31:0] d, input [2:0] p,
            output [31:0] rd, output err);
    int n;
    begin
      n = 0;
      @(posedge clk_i);
      #1;
      psel_o = 1'h1;
      pwrite_o = w;
      paddr_o = a;
      pwdata_o = d;
      pprot_o = p;
      @(posedge clk_i);
      #1;
      penable_o = 1'h1;
      do begin
        @(posedge clk_i);
        n++;
      end while (!pready_i && n < 20);
      rd = prdata_i;
      err = pready_i ? pslverr_i : 1'bx; // Unknown flags a timeout
      #1;
      psel_o = 1'h0;
      penable_o = 1'h0;
      paddr_o = ~a;
      pwdata_o = ~d;
    end
  endtask
endmodule

// >>> rtc_tamper_subsec_alarm_priv_tb.sv
`timescale 1ns/1ps
module rtc_tamper_subsec_alarm_priv_tb;
  localparam [2:0]  P = 3'h1;
  localparam [2:0]  U = 3'h0;
  localparam [31:0] EXT = 32'hA5C3_3C5A;
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
    logic [2:0]  p;
    logic [31:0] e;
    logic        err;
  } row_t;
  reg         ref_clk_i, rst_i, alarm0_on_i, alarm1_on_i, calendar_init_mode_i;
  reg  [1:0]  tamper_pin_i, tamper_seen_clr_i;
  reg  [15:0] subsec_count_i;
  wire [31:0] ext_rdata_i = EXT;
  wire        psel_i, penable_i, pwrite_i, pready_o, pslverr_o, tamper_pullup_o;
  wire        alarm0_subsec_match_o, alarm1_subsec_match_o, backup_wipe_o;
  wire        stamp_flag_set_o, tamper_irq_o, pp;
  wire [1:0]  tamper_seen_o;
  wire [2:0]  pprot_i;
  wire [11:0] paddr_i;
  wire [31:0] pwdata_i, prdata_o;
  int         n_mismatch, checks_done, wipe_cnt, stamp_cnt, pu_cnt, w0, s0;
  logic [31:0] rd;
  logic        er;
  logic [3:0]  mw [7] = '{4'h3, 4'h3, 4'h0, 4'hF, 4'hF, 4'h1, 4'h1};
  logic [15:0] sc [7] = '{16'hFFFD, 16'h0004, 16'h1234, 16'h8005, 16'h4005, 16'h0003,
                          16'h0002};
  logic        me [7] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0};
  row_t rows [20] = '{
    '{1'h0, 12'h050, 32'h0, U, 32'h0, 1'h0},
    '{1'h1, 12'h040, 32'hFFFF_FFFF, U, 32'h0, 1'h0},
    '{1'h0, 12'h040, 32'h0, U, 32'h001C_FF9F, 1'h0},
    '{1'h1, 12'h044, 32'hFFFF_FFFF, U, 32'h0, 1'h0},
    '{1'h0, 12'h044, 32'h0, U, 32'h0F00_7FFF, 1'h0},
    '{1'h0, 12'h0FC, 32'h0, U, 32'h0, 1'h1},
    '{1'h1, 12'h050, 32'hFFFF_FFFF, P, 32'h0, 1'h0},
    '{1'h0, 12'h050, 32'h0, P, 32'hC000_F00F, 1'h0},
    '{1'h1, 12'h040, 32'h0, U, 32'h0, 1'h1},
    '{1'h0, 12'h040, 32'h0, P, 32'h001C_FF9F, 1'h0},
    '{1'h1, 12'h044, 32'h0, U, 32'h0, 1'h1},
    '{1'h0, 12'h100, 32'h0, U, 32'h0, 1'h1},
    '{1'h1, 12'h120, 32'h0, U, 32'h0, 1'h1},
    '{1'h0, 12'h120, 32'h0, U, EXT, 1'h0},
    '{1'h1, 12'h000, 32'h0, U, 32'h0, 1'h1},
    '{1'h1, 12'h008, 32'h0, U, 32'h0, 1'h1},
    '{1'h1, 12'h000, 32'h0, P, 32'h0, 1'h0},
    '{1'h1, 12'h050, 32'h0, P, 32'h0, 1'h0},
    '{1'h1, 12'h000, 32'h0, U, 32'h0, 1'h0},
    '{1'h1, 12'h040, 32'h0, U, 32'h0, 1'h0}
  };

  rtc_tamper_subsec_alarm_priv #(.SAMPLE_BASE_LOG2(6)) DUT (
    .ref_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pprot_i, .prdata_o, .pready_o, .pslverr_o, .ext_wr_o(), .ext_rd_o(),
    .ext_addr_o(), .ext_wdata_o(), .ext_rdata_i, .tamper_pin_i,
    .tamper_pullup_o, .alarm0_on_i, .alarm1_on_i, .calendar_init_mode_i,
    .subsec_count_i, .alarm0_subsec_match_o, .alarm1_subsec_match_o,
    .backup_wipe_o, .stamp_flag_set_o, .tamper_seen_o, .tamper_seen_clr_i,
    .tamper_irq_o, .alarm_pushpull_o(pp)
  );

  apb_master_model u_mst (
    .clk_i(ref_clk_i), .pready_i(pready_o), .pslverr_i(pslverr_o),
    .prdata_i(prdata_o), .psel_o(psel_i), .penable_o(penable_i),
    .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i), .pprot_o(pprot_i)
  );

  initial begin
    ref_clk_i = 1'h0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    wipe_cnt += backup_wipe_o;
    stamp_cnt += stamp_flag_set_o;
    pu_cnt += tamper_pullup_o;
  end

  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done++;
      if (got !== exp) begin
        n_mismatch++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task wrap_up;
    begin
      $display("Checks made %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task cyc(input int n);
    begin
      repeat (n) @(posedge ref_clk_i);
      #1;
    end
  endtask

  task acc(input w, input [11:0] a, input [31:0] d, input [2:0] p);
    u_mst.xfer(w, a, d, p, rd, er);
  endtask

  task clear_seen;
    begin
      tamper_seen_clr_i = 2'h3;
      cyc(1);
      tamper_seen_clr_i = 2'h0;
      cyc(2);
    end
  endtask

  initial begin
    #200000;
    n_mismatch++;
    wrap_up;
  end

  initial begin
    rst_i = 1'h1;
    alarm0_on_i = 1'h0;
    alarm1_on_i = 1'h0;
    calendar_init_mode_i = 1'h0;
    tamper_pin_i = 2'h0;
    tamper_seen_clr_i = 2'h0;
    subsec_count_i = 16'h0;
    cyc(5);
    rst_i = 1'h0;
    chk({30'h0, tamper_seen_o}, 32'h0);
    foreach (rows[i]) begin
      acc(rows[i].w, rows[i].a, rows[i].d, rows[i].p);
      chk({31'h0, er}, {31'h0, rows[i].err});
      if (!rows[i].w) chk(rd, rows[i].e);
    end
    chk(wipe_cnt, 32'h1);
    // Alarm running outside init mode must drop the write silently
    alarm0_on_i = 1'h1;
    acc(1'h1, 12'h044, 32'h0300_0005, U);
    acc(1'h0, 12'h044, 32'h0, U);
    chk(rd, 32'h0F00_7FFF);
    calendar_init_mode_i = 1'h1;
    acc(1'h1, 12'h044, 32'h0300_0005, U);
    acc(1'h0, 12'h044, 32'h0, U);
    chk(rd, 32'h0300_0005);
    calendar_init_mode_i = 1'h0;
    alarm0_on_i = 1'h0;
    for (int k = 0; k < 7; k++) begin
      acc(1'h1, 12'h044, {4'h0, mw[k], 9'h0, 15'h0005}, U);
      subsec_count_i = sc[k];
      cyc(2);
      chk({31'h0, alarm0_subsec_match_o}, {31'h0, me[k]});
    end
    acc(1'h1, 12'h048, 32'h0F00_7FFF, U);
    subsec_count_i = 16'hFFFF;
    cyc(2);
    chk({31'h0, alarm1_subsec_match_o}, 32'h1);
    w0 = wipe_cnt;
    s0 = stamp_cnt;
    acc(1'h1, 12'h040, 32'h0000_0085, U);
    tamper_pin_i = 2'h1;
    cyc(20);
    chk({30'h0, tamper_seen_o}, 32'h1);
    chk(wipe_cnt - w0, 32'h1);
    chk(stamp_cnt - s0, 32'h1);
    chk({31'h0, tamper_irq_o}, 32'h1);
    clear_seen;
    tamper_pin_i = 2'h0;
    cyc(20);
    chk({30'h0, tamper_seen_o}, 32'h0);
    acc(1'h1, 12'h040, 32'h0, U);
    acc(1'h1, 12'h040, 32'h0008_0003, U);
    w0 = wipe_cnt;
    s0 = stamp_cnt;
    tamper_pin_i = 2'h1;
    cyc(20);
    tamper_pin_i = 2'h0;
    cyc(20);
    chk({30'h0, tamper_seen_o}, 32'h1);
    chk(wipe_cnt - w0, 32'h0);
    chk(stamp_cnt - s0, 32'h0);
    chk({31'h0, tamper_irq_o}, 32'h0);
    acc(1'h1, 12'h040, 32'h0, U);
    clear_seen;
    tamper_pin_i = 2'h3;
    cyc(20);
    chk({30'h0, tamper_seen_o}, 32'h0);
    w0 = wipe_cnt;
    acc(1'h1, 12'h040, 32'h0014_2B18, U);
    pu_cnt = 0;
    cyc(64);
    chk({30'h0, tamper_seen_o}, 32'h2);
    chk(wipe_cnt - w0, 32'h0);
    chk({31'h0, pu_cnt >= 12 && pu_cnt <= 18}, 32'h1);
    chk({31'h0, pp}, 32'h1);
    acc(1'h1, 12'h040, 32'h0, U);
    acc(1'h1, 12'h040, 32'h0000_6618, U);
    pu_cnt = 0;
    cyc(64);
    chk(pu_cnt, 32'h0);
    acc(1'h1, 12'h040, 32'h0, U);
    rst_i = 1'h1;
    cyc(5);
    rst_i = 1'h0;
    chk({30'h0, tamper_seen_o}, 32'h0);
    acc(1'h0, 12'h044, 32'h0, U);
    chk(rd, 32'h0);
    wrap_up;
  end
endmodule
